// ### core/dlct_pkg.sv
package dlct_pkg;
    // ***************************************************
    // Register addresses
    // ***************************************************
    localparam logic [7:0] ADDR_TCTL = 8'h88;
    localparam logic [7:0] ADDR_TIMER_MODE_CONFIG = 8'h89;
    localparam logic [7:0] ADDR_TLA = 8'h8a;
    localparam logic [7:0] ADDR_TLB = 8'h8b;
    localparam logic [7:0] ADDR_THA = 8'h8c;
    localparam logic [7:0] ADDR_THB = 8'h8d;
    localparam logic [7:0] ADDR_TCLK = 8'h8e;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] TCLK_MASK = 8'h1b;

    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int TCTL_TFB = 7;
    localparam int TCTL_TRB = 6;
    localparam int TCTL_TFA = 5;
    localparam int TCTL_TRA = 4;
    localparam int TCTL_IEB = 3;
    localparam int TCTL_ITB = 2;
    localparam int TCTL_IEA = 1;
    localparam int TCTL_ITA = 0;
    localparam int TIMER_MODE_CONFIG_GATEB = 7;
    localparam int TIMER_MODE_CONFIG_CTB = 6;
    localparam int TIMER_MODE_CONFIG_MODEB = 4;
    localparam int TIMER_MODE_CONFIG_GATEA = 3;
    localparam int TIMER_MODE_CONFIG_CTA = 2;
    localparam int TIMER_MODE_CONFIG_MODEA = 0;
    localparam int TCLK_SYSB = 4;
    localparam int TCLK_SYSA = 3;
    localparam int TCLK_PSC = 0;

    // ***************************************************
    // Modes and prescaler
    // ***************************************************
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [1:0] PSC_SYS12 = 2'h0;
    localparam logic [1:0] PSC_SYS4 = 2'h1;
    localparam logic [1:0] PSC_SYS48 = 2'h2;
    localparam logic [1:0] PSC_EXT8 = 2'h3;
    localparam logic [5:0] DIV_SYS12 = 6'h0c;
    localparam logic [5:0] DIV_SYS4 = 6'h04;
    localparam logic [5:0] DIV_SYS48 = 6'h30;
    localparam logic [2:0] DIV_EXT8_LAST = 3'h7;

    // ***************************************************
    // Count step: {overflow, high, low}
    // ***************************************************
    function automatic logic [16:0] dlct_step(input logic [1:0] mode,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [16:0] r;
        logic [13:0] c13;
        r = {1'b0, hi, lo};
        c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        unique case (mode)
            MODE_13BIT: r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
            MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
            MODE_RELOAD8: begin
                if (lo == 8'hff) begin
                    r = {1'b1, hi, hi};
                end else begin
                    r = {1'b0, hi, lo + 8'h01};
                end
            end
            MODE_SPLIT: r = {1'b0, hi, lo};
        endcase
        return r;
    endfunction
endpackage

// ### core/dlct_pin_sync.sv
module dlct_pin_sync
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Pin
    input wire logic pin,
    // Synchronised level and falling edge
    output logic lvl,
    output logic fall
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // Pins idle high, so reset to high avoids a false edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
            s3_ff <= 1'b1;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign lvl = s2_ff;
    assign fall = s3_ff & ~s2_ff;
endmodule

// ### core/dlct_prescaler.sv
module dlct_prescaler
    import dlct_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control
    input wire logic [1:0] prescale_select,
    input wire logic ext_clk_fall,
    // Prescaled tick
    output logic psc_tick
);
    logic [5:0] sys_cnt_ff;
    logic [2:0] ext_cnt_ff;
    logic tick_ff;
    logic nxt_tick;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sys_cnt_ff <= 6'h00;
        end else if (sys_cnt_ff == DIV_SYS48 - 6'h01) begin
            sys_cnt_ff <= 6'h00;
        end else begin
            sys_cnt_ff <= sys_cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ext_cnt_ff <= 3'h0;
        end else if (ext_clk_fall) begin
            ext_cnt_ff <= ext_cnt_ff + 3'h1;
        end
    end

    // One divider feeds all system-clock ratios, since 4 and 12 divide 48
    always_comb begin
        nxt_tick = 1'b0;
        unique case (prescale_select)
            PSC_SYS12: nxt_tick = (sys_cnt_ff % DIV_SYS12) == 6'h00;
            PSC_SYS4: nxt_tick = (sys_cnt_ff % DIV_SYS4) == 6'h00;
            PSC_SYS48: nxt_tick = sys_cnt_ff == 6'h00;
            PSC_EXT8: nxt_tick = ext_clk_fall &
                                 (ext_cnt_ff == DIV_EXT8_LAST);
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    assign psc_tick = tick_ff;
endmodule

// ### core/dlct_top.sv
// Behaviour
// - Mode 0: high byte plus low bits 4..0 form 13 bits.
// - 13-bit wrap sets overflow flag and may request interrupt.
// - Count-select counts pin falling edges, else internal clock.
// - System-clock select picks system clock, else prescaled clock.
// - Counting needs run set and gating off or gate pin high, except split timer A high byte and timer B.
// - Setting run never clears the count.
// - Mode 1 uses all 16 bits; wrap from maximum overflows.
// - Mode 2: low byte counts, reloads from high byte on wrap.
// - Split: timer A low byte uses timer A controls and flag.
// - Split: timer A high byte, timer B run, sets B flag.
// - Split: timer B modes 0-2 run internally, flag untouched.
// - Timer B mode 3 stops it.
// - Overflow flag set by hardware, cleared by write or vector.
// - External flag per type; edge mode auto-clears on vector.
// - Type 0 is active-low level, type 1 falling edge.
// - Timer B mirrors timer A with its own bytes and gate pin.
// - Overflow requests interrupt only if its enable is set.
// - Control register resets to zero with documented layout.
// - Mode field: 13-bit, 16-bit, reload, split or inactive.
// - Prescale: sys/12, sys/4, sys/48, external/8.
module dlct_top
    import dlct_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Pins
    input wire logic tmra_event_pin,
    input wire logic tmrb_event_pin,
    input wire logic ext_irq_a_n,
    input wire logic ext_irq_b_n,
    input wire logic ext_clk_in,
    // Interrupt enables and vector acknowledges
    input wire logic tmra_irq_enable,
    input wire logic tmrb_irq_enable,
    input wire logic tmra_irq_ack,
    input wire logic tmrb_irq_ack,
    input wire logic ext_irq_a_ack,
    input wire logic ext_irq_b_ack,
    // Requests and triggers
    output logic tmra_irq_req,
    output logic tmrb_irq_req,
    output logic ext_irq_a_req,
    output logic ext_irq_b_req,
    output logic tmrb_overflow_pulse
);
    // ***************************************************
    // State
    // ***************************************************
    logic [7:0] tmra_count_low_ff;
    logic [7:0] tmra_count_high_ff;
    logic [7:0] tmrb_count_low_ff;
    logic [7:0] tmrb_count_high_ff;
    logic [7:0] timer_mode_config_ff;
    logic [7:0] timer_clock_config_ff;
    logic tmra_overflow_flag_ff;
    logic tmrb_overflow_flag_ff;
    logic tmra_run_ff;
    logic tmrb_run_ff;
    logic ext_irq_a_flag_ff;
    logic ext_irq_b_flag_ff;
    logic ext_irq_a_edge_mode_ff;
    logic ext_irq_b_edge_mode_ff;
    logic [7:0] rdata_ff;
    logic ovf_pulse_ff;

    // ***************************************************
    // Pins and prescaler
    // ***************************************************
    logic ev_a_fall;
    logic ev_b_fall;
    logic irq_a_lvl;
    logic irq_a_fall;
    logic irq_b_lvl;
    logic irq_b_fall;
    logic ext_clk_fall;
    logic psc_tick;

    dlct_pin_sync u_sync_eva (.mclk(mclk), .nrst(nrst),
        .pin(tmra_event_pin), .lvl(), .fall(ev_a_fall));
    dlct_pin_sync u_sync_evb (.mclk(mclk), .nrst(nrst),
        .pin(tmrb_event_pin), .lvl(), .fall(ev_b_fall));
    dlct_pin_sync u_sync_irqa (.mclk(mclk), .nrst(nrst),
        .pin(ext_irq_a_n), .lvl(irq_a_lvl), .fall(irq_a_fall));
    dlct_pin_sync u_sync_irqb (.mclk(mclk), .nrst(nrst),
        .pin(ext_irq_b_n), .lvl(irq_b_lvl), .fall(irq_b_fall));
    dlct_pin_sync u_sync_ext (.mclk(mclk), .nrst(nrst),
        .pin(ext_clk_in), .lvl(), .fall(ext_clk_fall));

    dlct_prescaler u_psc (.mclk(mclk), .nrst(nrst),
        .prescale_select(timer_clock_config_ff[TCLK_PSC +: 2]),
        .ext_clk_fall(ext_clk_fall), .psc_tick(psc_tick));

    // ***************************************************
    // Count enables
    // ***************************************************
    logic wr_tctl;
    logic wr_tla;
    logic wr_tha;
    logic wr_tlb;
    logic wr_thb;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic split;
    logic clk_a;
    logic clk_b;
    logic en_a;
    logic en_b;
    logic inc_a;
    logic inc_ah;
    logic inc_b;
    logic [16:0] step_a;
    logic [16:0] step_b;
    logic ovf_a;
    logic ovf_ah;
    logic ovf_b;
    logic set_tfa;
    logic set_tfb;

    assign wr_tctl = sfr_wr & (sfr_addr == ADDR_TCTL);
    assign wr_tla = sfr_wr & (sfr_addr == ADDR_TLA);
    assign wr_tha = sfr_wr & (sfr_addr == ADDR_THA);
    assign wr_tlb = sfr_wr & (sfr_addr == ADDR_TLB);
    assign wr_thb = sfr_wr & (sfr_addr == ADDR_THB);
    assign mode_a = timer_mode_config_ff[TIMER_MODE_CONFIG_MODEA +: 2];
    assign mode_b = timer_mode_config_ff[TIMER_MODE_CONFIG_MODEB +: 2];
    assign split = mode_a == MODE_SPLIT;
    assign clk_a = timer_clock_config_ff[TCLK_SYSA] | psc_tick;
    assign clk_b = timer_clock_config_ff[TCLK_SYSB] | psc_tick;
    assign en_a = tmra_run_ff &
        (~timer_mode_config_ff[TIMER_MODE_CONFIG_GATEA] | irq_a_lvl);
    assign en_b = tmrb_run_ff &
        (~timer_mode_config_ff[TIMER_MODE_CONFIG_GATEB] | irq_b_lvl);
    assign inc_a = en_a & (timer_mode_config_ff[TIMER_MODE_CONFIG_CTA] ?
        ev_a_fall : clk_a);
    // High byte of a split timer A borrows timer B's run bit
    assign inc_ah = split & tmrb_run_ff & clk_a;
    // Split starves timer B of pin clocking and its run bit
    assign inc_b = (mode_b != MODE_SPLIT) & (split ? clk_b :
        en_b & (timer_mode_config_ff[TIMER_MODE_CONFIG_CTB] ? ev_b_fall : clk_b));
    assign step_a = dlct_step(mode_a, tmra_count_low_ff,
        tmra_count_high_ff);
    assign step_b = dlct_step(mode_b, tmrb_count_low_ff,
        tmrb_count_high_ff);
    assign ovf_a = inc_a & (split ? (tmra_count_low_ff == 8'hff) :
        step_a[16]);
    assign ovf_ah = inc_ah & (tmra_count_high_ff == 8'hff);
    assign ovf_b = inc_b & step_b[16];
    assign set_tfa = ovf_a;
    assign set_tfb = split ? ovf_ah : ovf_b;

    // ***************************************************
    // Count registers
    // ***************************************************
    // A software write to a byte wins over a count of that byte
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmra_count_low_ff <= REG_RESET;
        end else if (wr_tla) begin
            tmra_count_low_ff <= sfr_wdata;
        end else if (inc_a & split) begin
            tmra_count_low_ff <= tmra_count_low_ff + 8'h01;
        end else if (inc_a) begin
            tmra_count_low_ff <= step_a[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmra_count_high_ff <= REG_RESET;
        end else if (wr_tha) begin
            tmra_count_high_ff <= sfr_wdata;
        end else if (inc_ah) begin
            tmra_count_high_ff <= tmra_count_high_ff + 8'h01;
        end else if (inc_a & ~split) begin
            tmra_count_high_ff <= step_a[15:8];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmrb_count_low_ff <= REG_RESET;
        end else if (wr_tlb) begin
            tmrb_count_low_ff <= sfr_wdata;
        end else if (inc_b) begin
            tmrb_count_low_ff <= step_b[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmrb_count_high_ff <= REG_RESET;
        end else if (wr_thb) begin
            tmrb_count_high_ff <= sfr_wdata;
        end else if (inc_b) begin
            tmrb_count_high_ff <= step_b[15:8];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ovf_pulse_ff <= 1'b0;
        end else begin
            ovf_pulse_ff <= ovf_b;
        end
    end

    // ***************************************************
    // Configuration and control
    // ***************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            timer_mode_config_ff <= REG_RESET;
            timer_clock_config_ff <= REG_RESET;
        end else begin
            if (sfr_wr & (sfr_addr == ADDR_TIMER_MODE_CONFIG)) begin
                timer_mode_config_ff <= sfr_wdata;
            end
            if (sfr_wr & (sfr_addr == ADDR_TCLK)) begin
                timer_clock_config_ff <= sfr_wdata & TCLK_MASK;
            end
        end
    end

    // Run and edge-mode bits only; counts are left alone
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmra_run_ff <= 1'b0;
            tmrb_run_ff <= 1'b0;
            ext_irq_a_edge_mode_ff <= 1'b0;
            ext_irq_b_edge_mode_ff <= 1'b0;
        end else if (wr_tctl) begin
            tmra_run_ff <= sfr_wdata[TCTL_TRA];
            tmrb_run_ff <= sfr_wdata[TCTL_TRB];
            ext_irq_a_edge_mode_ff <= sfr_wdata[TCTL_ITA];
            ext_irq_b_edge_mode_ff <= sfr_wdata[TCTL_ITB];
        end
    end

    // Hardware set wins over a write or a vector clear
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmra_overflow_flag_ff <= 1'b0;
        end else if (set_tfa) begin
            tmra_overflow_flag_ff <= 1'b1;
        end else if (tmra_irq_ack) begin
            tmra_overflow_flag_ff <= 1'b0;
        end else if (wr_tctl) begin
            tmra_overflow_flag_ff <= sfr_wdata[TCTL_TFA];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tmrb_overflow_flag_ff <= 1'b0;
        end else if (set_tfb) begin
            tmrb_overflow_flag_ff <= 1'b1;
        end else if (tmrb_irq_ack) begin
            tmrb_overflow_flag_ff <= 1'b0;
        end else if (wr_tctl) begin
            tmrb_overflow_flag_ff <= sfr_wdata[TCTL_TFB];
        end
    end

    // Level mode tracks the inverted pin, so a clear only sticks
    // once the pin has returned high
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ext_irq_a_flag_ff <= 1'b0;
        end else if (!ext_irq_a_edge_mode_ff) begin
            ext_irq_a_flag_ff <= ~irq_a_lvl;
        end else if (irq_a_fall) begin
            ext_irq_a_flag_ff <= 1'b1;
        end else if (ext_irq_a_ack) begin
            ext_irq_a_flag_ff <= 1'b0;
        end else if (wr_tctl) begin
            ext_irq_a_flag_ff <= sfr_wdata[TCTL_IEA];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ext_irq_b_flag_ff <= 1'b0;
        end else if (!ext_irq_b_edge_mode_ff) begin
            ext_irq_b_flag_ff <= ~irq_b_lvl;
        end else if (irq_b_fall) begin
            ext_irq_b_flag_ff <= 1'b1;
        end else if (ext_irq_b_ack) begin
            ext_irq_b_flag_ff <= 1'b0;
        end else if (wr_tctl) begin
            ext_irq_b_flag_ff <= sfr_wdata[TCTL_IEB];
        end
    end

    // ***************************************************
    // Read port and requests
    // ***************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata_ff <= REG_RESET;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_TCTL: rdata_ff <= {tmrb_overflow_flag_ff,
                    tmrb_run_ff, tmra_overflow_flag_ff, tmra_run_ff,
                    ext_irq_b_flag_ff, ext_irq_b_edge_mode_ff,
                    ext_irq_a_flag_ff, ext_irq_a_edge_mode_ff};
                ADDR_TIMER_MODE_CONFIG: rdata_ff <= timer_mode_config_ff;
                ADDR_TLA: rdata_ff <= tmra_count_low_ff;
                ADDR_TLB: rdata_ff <= tmrb_count_low_ff;
                ADDR_THA: rdata_ff <= tmra_count_high_ff;
                ADDR_THB: rdata_ff <= tmrb_count_high_ff;
                ADDR_TCLK: rdata_ff <= timer_clock_config_ff;
                default: rdata_ff <= REG_RESET;
            endcase
        end
    end

    assign sfr_rdata = rdata_ff;
    assign tmra_irq_req = tmra_overflow_flag_ff & tmra_irq_enable;
    assign tmrb_irq_req = tmrb_overflow_flag_ff & tmrb_irq_enable;
    assign ext_irq_a_req = ext_irq_a_flag_ff;
    assign ext_irq_b_req = ext_irq_b_flag_ff;
    assign tmrb_overflow_pulse = ovf_pulse_ff;

    // ***************************************************
    // Assertions
    // ***************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_quiet_a;
        !wr_tla && !wr_tha;
    endsequence
    sequence s_wrap13_a;
        inc_a && !split && mode_a == MODE_13BIT &&
        tmra_count_low_ff[4:0] == 5'h1f && tmra_count_high_ff == 8'hff;
    endsequence

    AST_WRAP13: assert property (s_wrap13_a and s_quiet_a |=>
        tmra_overflow_flag_ff && tmra_count_high_ff == 8'h00 &&
        tmra_count_low_ff[4:0] == 5'h00)
        else $error("13-bit wrap missed");
    AST_HOLD: assert property (!en_a && !split && !wr_tla |=>
        $stable(tmra_count_low_ff))
        else $error("timer A counted while disabled");
    AST_RELOAD: assert property (inc_a && mode_a == MODE_RELOAD8 &&
        tmra_count_low_ff == 8'hff && !wr_tla && !wr_tha |=>
        tmra_count_low_ff == tmra_count_high_ff &&
        $stable(tmra_count_high_ff) && tmra_overflow_flag_ff)
        else $error("reload wrong");
    AST_WRAP16: assert property (inc_a && mode_a == MODE_16BIT &&
        tmra_count_low_ff == 8'hff && !wr_tla && !wr_tha |=>
        tmra_count_high_ff == $past(tmra_count_high_ff) + 8'h01)
        else $error("16-bit carry wrong");
    AST_SPLIT_HI: assert property (inc_ah && !wr_tha &&
        tmra_count_high_ff == 8'hff |=> tmrb_overflow_flag_ff)
        else $error("split high overflow lost");
    AST_B_STOP: assert property (mode_b == MODE_SPLIT && !wr_tlb &&
        !wr_thb |=> $stable(tmrb_count_low_ff) &&
        $stable(tmrb_count_high_ff))
        else $error("timer B ran in mode 3");
    AST_SPLIT_B: assert property (split && !set_tfb &&
        !tmrb_overflow_flag_ff && !wr_tctl |=> !tmrb_overflow_flag_ff)
        else $error("timer B flag set during split");
    AST_IRQ: assert property (set_tfa && tmra_irq_enable &&
        !tmra_irq_ack |=> tmra_irq_req [*2] or
        (tmra_irq_req ##1 (tmra_irq_ack || !tmra_irq_enable)))
        else $error("timer A request missing");
    AST_ACK: assert property (tmra_overflow_flag_ff && tmra_irq_ack &&
        !set_tfa |=> !tmra_overflow_flag_ff)
        else $error("vector clear failed");
    AST_LEVEL: assert property (!ext_irq_a_edge_mode_ff &&
        $stable(ext_irq_a_edge_mode_ff) |=>
        ext_irq_a_flag_ff == !$past(irq_a_lvl))
        else $error("level flag wrong");
    AST_RUN_SET: assert property ((wr_tctl && sfr_wdata[TCTL_TRA] &&
        !tmra_run_ff && !inc_a) and s_quiet_a |=>
        $stable(tmra_count_low_ff) && $stable(tmra_count_high_ff))
        else $error("run set disturbed count");
endmodule

// ### sim/dlct_pin_model.sv
// ***************************************************
// Event pin source, one fall per request
// ***************************************************
module dlct_pin_model
(
    // Clock
    input wire logic mclk,
    // Fall requests, bit 0 timer A, bit 1 timer B
    input wire logic [1:0] fire,
    // Event pins
    output logic tmra_event_pin,
    output logic tmrb_event_pin
);
    logic [1:0] low_a_ff = 2'h0;
    logic [1:0] low_b_ff = 2'h0;

    // Low held two clocks so the sampler cannot miss it
    always_ff @(posedge mclk) begin
        low_a_ff <= fire[0] ? 2'h2 : low_a_ff - {1'b0, |low_a_ff};
        low_b_ff <= fire[1] ? 2'h2 : low_b_ff - {1'b0, |low_b_ff};
    end
    assign tmra_event_pin = (low_a_ff == 2'h0);
    assign tmrb_event_pin = (low_b_ff == 2'h0);
endmodule

// ### sim/dual_legacy_counter_timer_tb.sv
module dual_legacy_counter_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dlct_pkg::*;
    logic mclk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, v, r;
    logic tmra_event_pin, tmrb_event_pin, ext_irq_a_n = 1, ext_irq_b_n = 1;
    logic ta_en = 0, tb_en = 0, ta_ack = 0, ea_ack = 0;
    logic ta_req, tb_req, ea_req, eb_req;
    logic [1:0] fire = 0;
    logic [7:0] npulse = 0, p0 = 0;
    logic ob;
    int err_total = 0, samples_checked = 0, seed = 64631;

    dlct_pin_model model (.mclk(mclk), .fire(fire),
        .tmra_event_pin(tmra_event_pin), .tmrb_event_pin(tmrb_event_pin));
    dlct_top DUT (.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .tmra_event_pin(tmra_event_pin),
        .tmrb_event_pin(tmrb_event_pin), .ext_irq_a_n(ext_irq_a_n),
        .ext_irq_b_n(ext_irq_b_n), .ext_clk_in(1'b0),
        .tmra_irq_enable(ta_en), .tmrb_irq_enable(tb_en),
        .tmra_irq_ack(ta_ack), .tmrb_irq_ack(1'b0),
        .ext_irq_a_ack(ea_ack), .ext_irq_b_ack(1'b0),
        .tmra_irq_req(ta_req), .tmrb_irq_req(tb_req),
        .ext_irq_a_req(ea_req), .ext_irq_b_req(eb_req),
        .tmrb_overflow_pulse(ob));

    initial begin
        forever #10 mclk = ~mclk;
    end

    // Counts timer B overflow trigger pulses
    always @(posedge mclk) begin
        npulse <= npulse + {7'h00, ob};
    end

    // ***************************************************
    // Shared tasks
    // ***************************************************
    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 sfr_addr = a; sfr_wdata = d; sfr_wr = 1;
        @(posedge mclk);
        #1 sfr_wr = 0;
    endtask
    // Mask lets 13-bit reads ignore the loose upper bits
    task rdchk(input logic [7:0] a, input logic [7:0] m,
               input logic [7:0] exp);
        @(posedge mclk);
        #1 sfr_addr = a; sfr_rd = 1;
        @(posedge mclk);
        #1 sfr_rd = 0;
        chk(sfr_rdata & m, exp);
    endtask
    task falls(input int s, input int n);
        repeat (n) begin
            @(posedge mclk);
            #1 fire[s] = 1;
            @(posedge mclk);
            #1 fire[s] = 0;
            cyc(4);
        end
        cyc(4);
    endtask
    task pulse_ack(input int s);
        @(posedge mclk);
        #1 if (s == 0) ta_ack = 1; else ea_ack = 1;
        @(posedge mclk);
        #1 ta_ack = 0; ea_ack = 0;
    endtask
    task end_sim;
        $display("checked %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ***************************************************
    // Scenarios
    // ***************************************************
    initial begin
        cyc(5);
        #1 nrst = 1;
        for (int a = 8'h88; a <= 8'h8e; a++)
            rdchk(a, 8'hff, 8'h00);
        rdchk(8'h90, 8'hff, 8'h00);
        wr(ADDR_TIMER_MODE_CONFIG, 8'h05);
        wr(ADDR_TLA, 8'hfd);
        wr(ADDR_THA, 8'hff);
        ta_en = 1;
        wr(ADDR_TCTL, 8'h10);
        rdchk(ADDR_TLA, 8'hff, 8'hfd);
        falls(0, 4);
        rdchk(ADDR_TLA, 8'hff, 8'h01);
        rdchk(ADDR_THA, 8'hff, 8'h00);
        rdchk(ADDR_TCTL, 8'hff, 8'h30);
        chk(ta_req, 1'b1);
        ta_en = 0;
        #1 chk(ta_req, 1'b0);
        pulse_ack(0);
        rdchk(ADDR_TCTL, 8'hff, 8'h10);
        v = $random(seed);
        wr(ADDR_TIMER_MODE_CONFIG, 8'h40);
        wr(ADDR_TLB, {v[7:5], 5'h1e});
        wr(ADDR_THB, 8'hff);
        wr(ADDR_TCTL, 8'h40);
        falls(1, 2);
        rdchk(ADDR_TLB, 8'h1f, 8'h00);
        rdchk(ADDR_THB, 8'hff, 8'h00);
        rdchk(ADDR_TCTL, 8'hff, 8'hc0);
        r = {1'b0, v[6:0]};
        wr(ADDR_TIMER_MODE_CONFIG, 8'h06);
        wr(ADDR_TLA, 8'hfe);
        wr(ADDR_THA, r);
        wr(ADDR_TCTL, 8'h10);
        falls(0, 3);
        rdchk(ADDR_TLA, 8'hff, r + 8'h01);
        rdchk(ADDR_THA, 8'hff, r);
        rdchk(ADDR_TCTL, 8'hff, 8'h30);
        wr(ADDR_TIMER_MODE_CONFIG, 8'h0d);
        wr(ADDR_TLA, 8'h00);
        wr(ADDR_TCTL, 8'h00);
        falls(0, 2);
        rdchk(ADDR_TLA, 8'hff, 8'h00);
        ext_irq_a_n = 0;
        wr(ADDR_TCTL, 8'h10);
        falls(0, 2);
        rdchk(ADDR_TLA, 8'hff, 8'h00);
        ext_irq_a_n = 1;
        falls(0, 2);
        rdchk(ADDR_TLA, 8'hff, 8'h02);
        wr(ADDR_TCTL, 8'h01);
        ext_irq_a_n = 0;
        ext_irq_b_n = 0;
        cyc(6);
        rdchk(ADDR_TCTL, 8'hff, 8'h0b);
        chk(ea_req, 1'b1);
        chk(eb_req, 1'b1);
        pulse_ack(1);
        rdchk(ADDR_TCTL, 8'hff, 8'h09);
        wr(ADDR_TCTL, 8'h00);
        cyc(6);
        rdchk(ADDR_TCTL, 8'hff, 8'h0a);
        ext_irq_a_n = 1;
        ext_irq_b_n = 1;
        cyc(6);
        rdchk(ADDR_TCTL, 8'hff, 8'h00);
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            tb_en = v[0];
            wr(ADDR_THB, v);
            rdchk(ADDR_THB, 8'hff, v);
        end
        // Split mode on system clock; no prescale ticks with ext clock idle
        wr(ADDR_TCLK, 8'hff);
        rdchk(ADDR_TCLK, 8'hff, TCLK_MASK);
        wr(ADDR_TIMER_MODE_CONFIG, 8'h33);
        wr(ADDR_TLA, 8'hf0);
        wr(ADDR_THA, 8'hf0);
        wr(ADDR_TLB, 8'h5a);
        wr(ADDR_TCTL, 8'h50);
        cyc(20);
        rdchk(ADDR_TCTL, 8'hff, 8'hf0);
        chk(tb_req, tb_en);
        rdchk(ADDR_TLB, 8'hff, 8'h5a);
        wr(ADDR_THB, 8'hff);
        wr(ADDR_TLB, 8'h1f);
        wr(ADDR_TCTL, 8'h00);
        p0 = npulse;
        wr(ADDR_TIMER_MODE_CONFIG, 8'h03);
        cyc(4);
        rdchk(ADDR_TCTL, 8'hff, 8'h00);
        chk(npulse - p0, 8'h01);
        end_sim;
    end

    initial begin
        cyc(20000);
        err_total++;
        end_sim;
    end
endmodule
